// ### core/dbs_pkg.sv
package dbs_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int SRC_W = 4;
   localparam int GROUPS = 6;

   localparam logic [ADDR_W-1:0] ADDR_RESERVED_A = 8'h1c;
   localparam logic [ADDR_W-1:0] ADDR_RESERVED_B = 8'h1d;
   localparam logic [ADDR_W-1:0] ADDR_CORR_SEL = 8'h1e;
   localparam logic [ADDR_W-1:0] ADDR_MIX_OSC_SEL = 8'h1f;

   localparam logic [DATA_W-1:0] RST_RESERVED = 16'h0000;
   localparam logic [DATA_W-1:0] RST_CORR_SEL = 16'h1111;
   localparam logic [DATA_W-1:0] RST_MIX_OSC_SEL = 16'h1140;
   localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;
   // writable bits of the second select register, bit 0 stays zero
   localparam logic [DATA_W-1:0] MIX_OSC_WMASK = 16'hfffe;

   // field low bits
   localparam int LSB_PAIR1_HI = 12;
   localparam int LSB_PAIR2_HI = 8;
   localparam int LSB_PAIR1_LO = 4;
   localparam int LSB_PAIR2_LO = 0;
   localparam int LSB_OSC = 4;
   localparam int LSB_FIFO_ROUTE = 2;
   localparam int BIT_SW_SYNC = 1;

   // source positions inside a four-bit enable field
   localparam int SRC_SW = 3;
   localparam int SRC_PIN = 2;
   localparam int SRC_OUTPUT_STROBE = 1;
   localparam int SRC_LAST = 0;

   localparam logic [SRC_W-1:0] FIFO_IN_STROBE_CODE = 4'h2;

   // group index of the update pulses
   localparam int GRP_OFFSET_P1 = 0;
   localparam int GRP_OFFSET_P2 = 1;
   localparam int GRP_GAIN_P1 = 2;
   localparam int GRP_GAIN_P2 = 3;
   localparam int GRP_MIXER_P1 = 4;
   localparam int GRP_MIXER_P2 = 5;
endpackage

// ### core/dbs_pin_sync.sv
`timescale 1ns/1ps
module dbs_pin_sync
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic pinIn,
   output logic level,
   output logic rise
);
   logic s1_q, s2_q, s3_q, lvl_q, rise_q;
   logic lvl_d, rise_d;

   always_comb
   begin
      lvl_d = lvl_q;
      // change accepted once stages two and three agree
      if (s2_q == s3_q)
      begin
         lvl_d = s3_q;
      end
      rise_d = lvl_d & ~lvl_q;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         lvl_q <= 1'b0;
         rise_q <= 1'b0;
      end
      else
      begin
         s1_q <= pinIn;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
         rise_q <= rise_d;
      end
   end

   assign level = lvl_q;
   assign rise = rise_q;
endmodule

// ### core/dbs_src_sel.sv
`timescale 1ns/1ps
module dbs_src_sel
(
   input wire logic [dbs_pkg::SRC_W-1:0] srcEn,
   input wire logic swEvent,
   input wire logic pinEvent,
   input wire logic ostrEvent,
   input wire logic lastEvent,
   output logic fire
);
   import dbs_pkg::*;

   // any enabled source fires the group
   always_comb
   begin
      fire = (srcEn[SRC_SW] & swEvent) | (srcEn[SRC_PIN] & pinEvent)
         | (srcEn[SRC_OUTPUT_STROBE] & ostrEvent) | (srcEn[SRC_LAST] & lastEvent);
   end
endmodule

// ### core/double_buffer_sync_select.sv
// Notes on behaviour
// - bits 15:12 of first select pick sources for pair1 offset update.
// - bits 11:8 of first select pick sources for pair2 offset update.
// - bits 7:4 of first select pick sources for pair1 gain/phase update.
// - bits 3:0 of first select pick sources for pair2 gain/phase update.
// - bits 15:12 of second select pick sources for pair1 mixer update.
// - bits 11:8 of second select pick sources for pair2 mixer update.
// - bits 7:4 pick oscillator accumulator sync sources; reset value 0100 enables sync pin.
// - bits 3:2 route input strobe or sync pin to fifo strobe path while fifoInSrcSel is FIFO_IN_STROBE_CODE; otherwise input strobe.
// - host pulses bit 1 for software sync; fed to every enabling selector.
// - reserved registers and bit 0 reset to zero and stay there.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module double_buffer_sync_select
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [dbs_pkg::ADDR_W-1:0] regAddr,
   input wire logic [dbs_pkg::DATA_W-1:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [dbs_pkg::DATA_W-1:0] regRdData,
   input wire logic syncPin,
   input wire logic inputStrobePin,
   input wire logic outputStrobePin,
   input wire logic [dbs_pkg::SRC_W-1:0] fifoInSrcSel,
   input wire logic [dbs_pkg::GROUPS-1:0] shadowWrite,
   output logic [dbs_pkg::GROUPS-1:0] groupLoad,
   output logic oscSync,
   output logic fifoStrobePath
);
   import dbs_pkg::*;

   // register file
   logic [DATA_W-1:0] corrSel_q, corrSel_d;
   logic [DATA_W-1:0] mixSel_q, mixSel_d;
   logic [DATA_W-1:0] rdData_q, rdData_d;

   always_comb
   begin
      corrSel_d = corrSel_q;
      mixSel_d = mixSel_q;
      rdData_d = READ_ZERO;
      if (regWrEn)
      begin
         case (regAddr)
            ADDR_CORR_SEL: corrSel_d = regWrData;
            ADDR_MIX_OSC_SEL: mixSel_d = regWrData & MIX_OSC_WMASK;
            default: corrSel_d = corrSel_q;
         endcase
      end
      if (regRdEn)
      begin
         case (regAddr)
            ADDR_RESERVED_A: rdData_d = RST_RESERVED;
            ADDR_RESERVED_B: rdData_d = RST_RESERVED;
            ADDR_CORR_SEL: rdData_d = corrSel_q;
            ADDR_MIX_OSC_SEL: rdData_d = mixSel_q;
            default: rdData_d = READ_ZERO;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         corrSel_q <= RST_CORR_SEL;
         mixSel_q <= RST_MIX_OSC_SEL;
         rdData_q <= READ_ZERO;
      end
      else
      begin
         corrSel_q <= corrSel_d;
         mixSel_q <= mixSel_d;
         rdData_q <= rdData_d;
      end
   end

   assign regRdData = rdData_q;

   // pin conditioning
   logic syncLvl, syncRise, istrLvl, istrRise, ostrRise;

   dbs_pin_sync uSyncPin
   (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .pinIn(syncPin),
      .level(syncLvl),
      .rise(syncRise)
   );

   dbs_pin_sync uIstrPin
   (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .pinIn(inputStrobePin),
      .level(istrLvl),
      .rise(istrRise)
   );

   dbs_pin_sync uOstrPin
   (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .pinIn(outputStrobePin),
      .level(),
      .rise(ostrRise)
   );

   // software sync edge
   logic swPrev_q, swPrev_d, swEvent;

   always_comb
   begin
      swPrev_d = mixSel_q[BIT_SW_SYNC];
      swEvent = mixSel_q[BIT_SW_SYNC] & ~swPrev_q;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         swPrev_q <= 1'b0;
      end
      else
      begin
         swPrev_q <= swPrev_d;
      end
   end

   // per group source selection
   logic [SRC_W-1:0] grpEn [GROUPS];
   logic [GROUPS-1:0] grpFire;
   logic oscFire;

   always_comb
   begin
      grpEn[GRP_OFFSET_P1] = corrSel_q[LSB_PAIR1_HI +: SRC_W];
      grpEn[GRP_OFFSET_P2] = corrSel_q[LSB_PAIR2_HI +: SRC_W];
      grpEn[GRP_GAIN_P1] = corrSel_q[LSB_PAIR1_LO +: SRC_W];
      grpEn[GRP_GAIN_P2] = corrSel_q[LSB_PAIR2_LO +: SRC_W];
      grpEn[GRP_MIXER_P1] = mixSel_q[LSB_PAIR1_HI +: SRC_W];
      grpEn[GRP_MIXER_P2] = mixSel_q[LSB_PAIR2_HI +: SRC_W];
   end

   genvar g;
   generate
      for (g = 0; g < GROUPS; g++)
      begin : gSel
         dbs_src_sel uSel
         (
            .srcEn(grpEn[g]),
            .swEvent(swEvent),
            .pinEvent(syncRise),
            .ostrEvent(ostrRise),
            .lastEvent(shadowWrite[g]),
            .fire(grpFire[g])
         );
      end
   endgenerate

   dbs_src_sel uOscSel
   (
      .srcEn(mixSel_q[LSB_OSC +: SRC_W]),
      .swEvent(swEvent),
      .pinEvent(syncRise),
      .ostrEvent(ostrRise),
      .lastEvent(istrRise),
      .fire(oscFire)
   );

   // fifo strobe routing
   logic routeSync;
   logic fifoPath_d, fifoPath_q;

   always_comb
   begin
      // codes 01 and 11 select the sync pin
      routeSync = mixSel_q[LSB_FIFO_ROUTE];
      fifoPath_d = istrLvl;
      if ((fifoInSrcSel == FIFO_IN_STROBE_CODE) && routeSync)
      begin
         fifoPath_d = syncLvl;
      end
   end

   // update pulses
   logic [GROUPS-1:0] load_q, load_d;
   logic osc_q, osc_d;

   always_comb
   begin
      load_d = grpFire;
      osc_d = oscFire;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         load_q <= '0;
         osc_q <= 1'b0;
         fifoPath_q <= 1'b0;
      end
      else
      begin
         load_q <= load_d;
         osc_q <= osc_d;
         fifoPath_q <= fifoPath_d;
      end
   end

   assign groupLoad = load_q;
   assign oscSync = osc_q;
   assign fifoStrobePath = fifoPath_q;
endmodule

// ### testbench/dbs_checker_asserts.sv
`timescale 1ns/1ps
module dbs_checker
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [dbs_pkg::ADDR_W-1:0] regAddr,
   input wire logic [dbs_pkg::DATA_W-1:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [dbs_pkg::DATA_W-1:0] regRdData,
   input wire logic [dbs_pkg::GROUPS-1:0] shadowWrite,
   input wire logic [dbs_pkg::GROUPS-1:0] groupLoad,
   input wire logic oscSync
);
   import dbs_pkg::*;
   logic [31:0] sel_q;
   logic [31:0] sel_d;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   always_comb
   begin
      sel_d = sel_q;
      if (regWrEn && regAddr == ADDR_CORR_SEL)
         sel_d[15:0] = regWrData;
      if (regWrEn && regAddr == ADDR_MIX_OSC_SEL)
         sel_d[31:16] = regWrData & MIX_OSC_WMASK;
   end
   always_ff @(posedge sys_clk)
      sel_q <= resetn ? sel_d : {RST_MIX_OSC_SEL, RST_CORR_SEL};
   sequence s_sw_rise;
      regWrEn && regAddr == ADDR_MIX_OSC_SEL && regWrData[1] && !sel_q[17];
   endsequence
   property p_rd(a, v);
      $past(regRdEn && regAddr == a) |-> regRdData == v;
   endproperty
   property p_auto(int g, int b);
      shadowWrite[g] && sel_q[b] |=> groupLoad[g];
   endproperty
   a_rd_corr: assert property (p_rd(ADDR_CORR_SEL, $past(sel_q[15:0])))
      else $error("rd");
   a_rd_mix: assert property (p_rd(ADDR_MIX_OSC_SEL, $past(sel_q[31:16])))
      else $error("rd");
   a_rd_rsvd_a: assert property (p_rd(ADDR_RESERVED_A, READ_ZERO))
      else $error("rd");
   a_rd_rsvd_b: assert property (p_rd(ADDR_RESERVED_B, READ_ZERO))
      else $error("rd");
   a_auto_offset: assert property (p_auto(0, 12))
      else $error("auto");
   a_auto_mixer: assert property (p_auto(5, 24))
      else $error("auto");
   a_sw_mixer: assert property (s_sw_rise ##0 regWrData[15] |-> ##2 groupLoad[4])
      else $error("sw");
   a_sw_osc: assert property (s_sw_rise ##0 regWrData[7] |-> ##2 oscSync)
      else $error("sw");
endmodule
bind double_buffer_sync_select dbs_checker dbs_checker_i (.sys_clk, .resetn, .regAddr,
   .regWrData, .regWrEn, .regRdEn, .regRdData, .shadowWrite, .groupLoad, .oscSync);

// ### testbench/dbs_host.sv
`timescale 1ns/1ps
module dbs_host
(
   input wire logic sys_clk,
   output logic [dbs_pkg::ADDR_W-1:0] regAddr,
   output logic [dbs_pkg::DATA_W-1:0] regWrData,
   output logic regWrEn,
   output logic regRdEn,
   input wire logic [dbs_pkg::DATA_W-1:0] regRdData
);
   import dbs_pkg::*;
   initial
   begin
      regAddr = '0;
      regWrData = '0;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge sys_clk);
      regWrEn <= 1'b0;
      regWrData <= ~d;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge sys_clk);
      regRdEn <= 1'b0;
      #1 d = regRdData;
   endtask
endmodule

// ### testbench/tb_double_buffer_sync_select.sv
`timescale 1ns/1ps
module tb_double_buffer_sync_select;
   import dbs_pkg::*;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic regWrEn, regRdEn, oscSync, fifoStrobePath;
   logic syncPin = 1'b0, inputStrobePin = 1'b0, outputStrobePin = 1'b0;
   logic [7:0] regAddr;
   logic [15:0] regWrData, regRdData;
   logic [3:0] fifoInSrcSel = '0;
   logic [5:0] shadowWrite = '0, groupLoad;
   int err_count = 0, samples_checked = 0;
   always #20 sys_clk = ~sys_clk;
   dbs_host dbs_host_i (.sys_clk, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData);
   double_buffer_sync_select double_buffer_sync_select_i (.sys_clk, .resetn, .regAddr,
      .regWrData, .regWrEn, .regRdEn, .regRdData, .syncPin, .inputStrobePin,
      .outputStrobePin, .fifoInSrcSel, .shadowWrite, .groupLoad, .oscSync, .fifoStrobePath);
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e)
      begin
         err_count++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] d;
      dbs_host_i.rd(a, d);
      chk("regRdData", e, d);
   endtask
   task automatic poll(output logic [5:0] gl, output logic os);
      gl = '0;
      os = 1'b0;
      repeat (10)
      begin
         @(posedge sys_clk);
         #1 gl |= groupLoad;
         os |= oscSync;
      end
   endtask
   task automatic shadow(input logic [5:0] e);
      @(posedge sys_clk);
      shadowWrite <= 6'h3f;
      @(posedge sys_clk);
      shadowWrite <= 6'h00;
      #1 chk("groupLoad", {10'h000, e}, {10'h000, groupLoad});
   endtask
   task automatic results();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic t_reset();
      logic [5:0] gl;
      logic os;
      rdc(ADDR_RESERVED_A, 16'h0000);
      rdc(ADDR_RESERVED_B, 16'h0000);
      rdc(ADDR_CORR_SEL, 16'h1111);
      rdc(ADDR_MIX_OSC_SEL, 16'h1140);
      rdc(8'h20, 16'h0000);
      @(posedge sys_clk);
      outputStrobePin <= 1'b1;
      poll(gl, os);
      chk("oscSync", 16'h0000, {15'h0000, os});
      chk("groupLoad", 16'h0000, {10'h000, gl});
      @(posedge sys_clk);
      syncPin <= 1'b1;
      poll(gl, os);
      chk("oscSync", 16'h0001, {15'h0000, os});
      chk("groupLoad", 16'h0000, {10'h000, gl});
      @(posedge sys_clk);
      syncPin <= 1'b0;
      outputStrobePin <= 1'b0;
      poll(gl, os);
      chk("oscSync", 16'h0000, {15'h0000, os});
      $display("t_reset done");
   endtask
   task automatic t_auto();
      shadow(6'h3f);
      dbs_host_i.wr(ADDR_MIX_OSC_SEL, 16'h0000);
      shadow(6'h0f);
      dbs_host_i.wr(ADDR_CORR_SEL, 16'h0100);
      shadow(6'h02);
      $display("t_auto done");
   endtask
   task automatic t_regs();
      dbs_host_i.wr(ADDR_CORR_SEL, 16'ha5c3);
      dbs_host_i.wr(ADDR_MIX_OSC_SEL, 16'h5a54);
      dbs_host_i.wr(ADDR_RESERVED_B, 16'h0000);
      rdc(ADDR_CORR_SEL, 16'ha5c3);
      rdc(ADDR_MIX_OSC_SEL, 16'h5a54);
      rdc(ADDR_RESERVED_B, 16'h0000);
      $display("t_regs done");
   endtask
   task automatic t_sw();
      dbs_host_i.wr(ADDR_CORR_SEL, 16'h8888);
      dbs_host_i.wr(ADDR_MIX_OSC_SEL, 16'h8880);
      dbs_host_i.wr(ADDR_MIX_OSC_SEL, 16'h8882);
      @(posedge sys_clk);
      #1 chk("groupLoad", 16'h003f, {10'h000, groupLoad});
      chk("oscSync", 16'h0001, {15'h0000, oscSync});
      dbs_host_i.wr(ADDR_MIX_OSC_SEL, 16'h8882);
      @(posedge sys_clk);
      #1 chk("groupLoad", 16'h0000, {10'h000, groupLoad});
      $display("t_sw done");
   endtask
   task automatic t_fifo();
      logic [5:0] gl;
      logic os;
      dbs_host_i.wr(ADDR_CORR_SEL, 16'h4000);
      dbs_host_i.wr(ADDR_MIX_OSC_SEL, 16'h0004);
      @(posedge sys_clk);
      fifoInSrcSel <= FIFO_IN_STROBE_CODE;
      syncPin <= 1'b1;
      poll(gl, os);
      chk("groupLoad", 16'h0001, {10'h000, gl});
      chk("fifoStrobePath", 16'h0001, {15'h0000, fifoStrobePath});
      @(posedge sys_clk);
      fifoInSrcSel <= 4'h0;
      repeat (2) @(posedge sys_clk);
      #1 chk("fifoStrobePath", 16'h0000, {15'h0000, fifoStrobePath});
      @(posedge sys_clk);
      fifoInSrcSel <= FIFO_IN_STROBE_CODE;
      dbs_host_i.wr(ADDR_MIX_OSC_SEL, 16'h0018);
      poll(gl, os);
      chk("fifoStrobePath", 16'h0000, {15'h0000, fifoStrobePath});
      @(posedge sys_clk);
      inputStrobePin <= 1'b1;
      poll(gl, os);
      chk("oscSync", 16'h0001, {15'h0000, os});
      chk("groupLoad", 16'h0000, {10'h000, gl});
      chk("fifoStrobePath", 16'h0001, {15'h0000, fifoStrobePath});
      $display("t_fifo done");
   endtask
   initial
   begin
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      t_reset();
      t_auto();
      t_regs();
      t_sw();
      t_fifo();
      results();
   end
   initial
   begin
      repeat (3000) @(posedge sys_clk);
      err_count++;
      results();
   end
endmodule
